// >>> design/bmp_pkg.sv
// constants and types for the bridge mode, strap and tlp policy block
// How it works
// - all mode pins low: eeprom, arbiter, forward
// - iface_select high with mode_select_hi low: smbus slave, sda open drain
// - direction_select low: forward bridge
// - direction_select high: reverse bridge
// - mode_select_hi low: sample req straps at perst
// - straps all zero: clock power management on
// - mode_select_hi high: strap at qualifying reset release
// - strapped values pick short init or test
// - fmt field gives header size and data
// - payload from 1 to 64 dwords
// - route by address, id or implicitly
// - advanced switching messages not supported
// - message destination from type bits 2:0
// - baseline messages use traffic class zero
// - virtual isochronous off after reset, bit 26
// - control bits pick upstream classes 1 to 7
// - downstream cfg, io, msg need tc zero
// - downstream memory goes to pci unless its payload is over 64 dwords
// - type 0/1 headers, capability ids 01h-10h
// - forward: port type reads 7h
// - reverse: port type reads 8h
// - capability version reads 1h
package bmp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_EXPRESS_CAP = 8'h02;
   localparam logic [7:0] IDX_CHIP_CTRL = 8'h40;
   localparam logic [7:0] IDX_STRAP_STAT = 8'h48;
   localparam int VI_EN_BIT = 26;
   localparam int UP_TC_LSB = 17;
   localparam logic [3:0] CAP_VERSION = 4'h1;
   localparam logic [3:0] PORT_FWD = 4'h7;
   localparam logic [3:0] PORT_REV = 4'h8;
   localparam logic [7:0] CAP_ID_FIRST = 8'h01;
   localparam logic [7:0] CAP_ID_LAST = 8'h10;
   localparam logic [31:0] CHIP_CTRL_RST = 32'h0000_0000;
   localparam logic [6:0] MAX_PAYLOAD_DW = 7'h40;
   localparam logic [1:0] REQ_STRAP_CPM = 2'h0;

   typedef enum logic [1:0] {BMP_RT_ADDR, BMP_RT_ID, BMP_RT_IMPL, BMP_RT_NONE} bmp_route_t;
   typedef enum logic [1:0] {BMP_TF_NONE, BMP_TF_SHORT_INIT, BMP_TF_LOOPBACK, BMP_TF_BRIDGE_TEST} bmp_test_t;

   // header dwords: fmt bit 0 picks 3 or 4
   function automatic logic [2:0] hdr_dwords(input logic [1:0] fmt);
      return fmt[0] ? 3'h4 : 3'h3;
   endfunction
endpackage

// >>> design/bmp_top.sv
// mode selection, strap capture and tlp policy checks of the bridge
`timescale 1ns/1ns
module bmp_top
   import bmp_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // mode and strap pins
   input wire logic mode_select_hi,
   input wire logic iface_select,
   input wire logic direction_select,
   input wire logic [3:2] pci_req_n,
   input wire logic perst_n,
   input wire logic pci_reset_n,
   // serial engine drive requests and shared pins
   input wire logic ser_scl,
   input wire logic ser_sda,
   input wire logic ser_sda_en,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe,
   // mode outputs
   output logic smbus_mode,
   output logic reverse_mode,
   output logic internal_arbiter,
   output logic strap_valid,
   output logic cpm_enable,
   output logic pci_clock_out_2_is_clkreq,
   output logic pci_clock_out_3_is_clkrun,
   output bmp_test_t test_func,
   // tlp header in
   input wire logic tlp_valid,
   input wire logic tlp_downstream,
   input wire logic [1:0] tlp_fmt,
   input wire logic [4:0] tlp_type,
   input wire logic [2:0] tlp_tc,
   input wire logic [9:0] tlp_length,
   // tlp decision out
   output logic dec_valid,
   output logic [2:0] dec_hdr_dw,
   output logic dec_has_data,
   output bmp_route_t dec_route,
   output logic [2:0] dec_msg_dest,
   output logic dec_malformed,
   output logic dec_unsupported,
   output logic dec_to_pci,
   output logic dec_vi_tc_hit,
   // register port
   input wire logic [9:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // pins are asynchronous to clk_sys, so every one gets two flops
   logic [6:0] pin_s1_reg, pin_s2_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_s1_reg <= 7'h00;
         pin_s2_reg <= 7'h00;
      end else begin
         pin_s1_reg <= {mode_select_hi, iface_select, direction_select, pci_req_n, perst_n, pci_reset_n};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   logic tm_hi, tm_if, tm_dir, perst_s, pcirst_s;
   logic [1:0] req_s;
   assign tm_hi = pin_s2_reg[6];
   assign tm_if = pin_s2_reg[5];
   assign tm_dir = pin_s2_reg[4];
   assign req_s = pin_s2_reg[3:2];
   assign perst_s = pin_s2_reg[1];
   assign pcirst_s = pin_s2_reg[0];

   // ----------------------------------------
   // live mode decode
   // ----------------------------------------
   // mode pins are trusted to stay put, so no glitch filter here
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         smbus_mode <= 1'b0;
         reverse_mode <= 1'b0;
         internal_arbiter <= 1'b1;
      end else begin
         smbus_mode <= ~tm_hi & tm_if;
         reverse_mode <= tm_dir;
         internal_arbiter <= ~tm_dir;
      end
   end

   // eeprom: drive scl and sda; smbus: scl input, sda pulls low only
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         scl_o <= 1'b1;
         scl_oe <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
      end else if (smbus_mode) begin
         scl_o <= 1'b1;
         scl_oe <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= ser_sda_en & ~ser_sda;
      end else begin
         scl_o <= ser_scl;
         scl_oe <= 1'b1;
         sda_o <= ser_sda;
         sda_oe <= ser_sda_en;
      end
   end

   // ----------------------------------------
   // strap capture
   // ----------------------------------------
   logic perst_d_reg, pcirst_d_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         perst_d_reg <= 1'b0;
         pcirst_d_reg <= 1'b0;
      end else begin
         perst_d_reg <= perst_s;
         pcirst_d_reg <= pcirst_s;
      end
   end
   // reverse bridge with test straps waits for the pci reset instead
   logic use_pcirst, qual_rise, qual_fall;
   assign use_pcirst = tm_hi & tm_dir;
   assign qual_rise = use_pcirst ? (pcirst_s & ~pcirst_d_reg) : (perst_s & ~perst_d_reg);
   assign qual_fall = use_pcirst ? (~pcirst_s & pcirst_d_reg) : (~perst_s & perst_d_reg);

   logic st_hi_reg, st_if_reg, st_dir_reg;
   logic [1:0] st_req_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_hi_reg <= 1'b0;
         st_if_reg <= 1'b0;
         st_dir_reg <= 1'b0;
         st_req_reg <= 2'h3;
      end else if (qual_rise) begin
         st_hi_reg <= tm_hi;
         st_if_reg <= tm_if;
         st_dir_reg <= tm_dir;
         st_req_reg <= req_s;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap_valid <= 1'b0;
      end else if (qual_rise) begin
         strap_valid <= 1'b1;
      end else if (qual_fall) begin
         strap_valid <= 1'b0;
      end
   end

   // decode uses the captured values, so pin motion later has no effect
   logic cpm_next;
   bmp_test_t test_next;
   always_comb begin
      cpm_next = 1'b0;
      test_next = BMP_TF_NONE;
      if (!st_hi_reg) begin
         cpm_next = (st_req_reg == REQ_STRAP_CPM) & ~st_dir_reg;
      end else if (st_if_reg) begin
         test_next = BMP_TF_SHORT_INIT;
      end else if (st_dir_reg) begin
         test_next = BMP_TF_LOOPBACK;
      end else begin
         test_next = BMP_TF_BRIDGE_TEST;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cpm_enable <= 1'b0;
         pci_clock_out_2_is_clkreq <= 1'b0;
         pci_clock_out_3_is_clkrun <= 1'b0;
         test_func <= BMP_TF_NONE;
      end else begin
         cpm_enable <= strap_valid & cpm_next;
         pci_clock_out_2_is_clkreq <= strap_valid & cpm_next;
         pci_clock_out_3_is_clkrun <= strap_valid & cpm_next;
         test_func <= strap_valid ? test_next : BMP_TF_NONE;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [31:0] chip_ctrl_reg;
   logic [7:0] idx;
   logic idx_ok;
   assign idx = reg_addr[9:2];
   assign idx_ok = reg_addr[1:0] == 2'h0;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chip_ctrl_reg <= CHIP_CTRL_RST;
      end else if (reg_wr && idx_ok && idx == IDX_CHIP_CTRL) begin
         chip_ctrl_reg <= reg_wdata;
      end
   end
   logic vi_en;
   logic [7:0] up_tc_mask;
   assign vi_en = chip_ctrl_reg[VI_EN_BIT];
   // class zero is never upstream isochronous, so its slot is tied off
   assign up_tc_mask = {chip_ctrl_reg[UP_TC_LSB +: 7], 1'b0};

   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      if (idx_ok) begin
         unique case (idx)
            IDX_EXPRESS_CAP: rd_next = {24'h00_0000, reverse_mode ? PORT_REV : PORT_FWD, CAP_VERSION};
            IDX_CHIP_CTRL: rd_next = chip_ctrl_reg;
            IDX_STRAP_STAT: rd_next = {23'h00_0000, test_func, cpm_enable, strap_valid,
                                       st_req_reg, st_dir_reg, st_if_reg, st_hi_reg};
            default: rd_next = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? rd_next : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // tlp policy
   // ----------------------------------------
   logic is_mem, is_io, is_cfg, is_msg, is_as, has_data, len_bad, tc_bad;
   logic [10:0] pay_dw;
   bmp_route_t route_next;
   assign is_mem = tlp_type[4:1] == 4'h0;
   assign is_io = tlp_type == 5'h02;
   assign is_cfg = tlp_type[4:1] == 4'h2;
   assign is_msg = tlp_type[4:3] == 2'h2;
   assign is_as = tlp_type[4:3] == 2'h3;
   assign has_data = tlp_fmt[1];
   // a zero length field stands for 1024 dwords
   assign pay_dw = (tlp_length == 10'h000) ? 11'h400 : {1'b0, tlp_length};
   assign len_bad = has_data & (pay_dw > {4'h0, MAX_PAYLOAD_DW});
   assign tc_bad = (tlp_tc != 3'h0) & (is_msg | (tlp_downstream & (is_io | is_cfg)));
   always_comb begin
      route_next = BMP_RT_NONE;
      if (is_mem || is_io) begin
         route_next = BMP_RT_ADDR;
      end else if (is_cfg) begin
         route_next = BMP_RT_ID;
      end else if (is_msg) begin
         route_next = BMP_RT_IMPL;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dec_valid <= 1'b0;
         dec_hdr_dw <= 3'h3;
         dec_has_data <= 1'b0;
         dec_route <= BMP_RT_NONE;
         dec_msg_dest <= 3'h0;
         dec_malformed <= 1'b0;
         dec_unsupported <= 1'b0;
         dec_to_pci <= 1'b0;
         dec_vi_tc_hit <= 1'b0;
      end else begin
         dec_valid <= tlp_valid;
         dec_hdr_dw <= hdr_dwords(tlp_fmt);
         dec_has_data <= has_data;
         dec_route <= route_next;
         dec_msg_dest <= is_msg ? tlp_type[2:0] : 3'h0;
         dec_malformed <= tlp_valid & (tc_bad | len_bad);
         dec_unsupported <= tlp_valid & is_as;
         dec_to_pci <= tlp_valid & tlp_downstream & is_mem & ~len_bad;
         dec_vi_tc_hit <= tlp_valid & ~tlp_downstream & vi_en & (tlp_tc != 3'h0) & up_tc_mask[tlp_tc];
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_port_type_fwd: assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 $past(reg_rd) && $past(reg_addr) == {IDX_EXPRESS_CAP, 2'h0} && !reverse_mode
      |-> reg_rdata[7:4] == PORT_FWD) else $error("port type not 7h in forward mode");
   a_port_type_rev: assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 $past(reg_rd) && $past(reg_addr) == {IDX_EXPRESS_CAP, 2'h0} && reverse_mode
      |-> reg_rdata[7:4] == PORT_REV) else $error("port type not 8h in reverse mode");
   a_cap_version: assert property (@(posedge clk_sys) disable iff (!resetn)
      reg_rd && reg_addr == {IDX_EXPRESS_CAP, 2'h0} |=> reg_rdata[3:0] == CAP_VERSION)
      else $error("capability version not 1h");
   a_vi_write: assert property (@(posedge clk_sys) disable iff (!resetn)
      reg_wr && reg_addr == {IDX_CHIP_CTRL, 2'h0} |=> vi_en == $past(reg_wdata[VI_EN_BIT]))
      else $error("virtual isochronous enable not taken");
   a_tc_malformed: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && tlp_downstream && (is_cfg || is_io) && tlp_tc != 3'h0 |=> dec_malformed)
      else $error("nonzero tc on cfg or io not malformed");
   a_mem_to_pci: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && tlp_downstream && is_mem && has_data && tlp_length == 10'h040 |=> dec_to_pci)
      else $error("downstream memory tlp not sent to pci");
   a_payload_max: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && has_data && tlp_length == 10'h041 |=> dec_malformed && !dec_to_pci)
      else $error("oversize payload accepted");
   a_msg_dest: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && is_msg |=> dec_route == BMP_RT_IMPL && dec_msg_dest == $past(tlp_type[2:0]))
      else $error("message destination wrong");
   a_hdr_size: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid |=> dec_hdr_dw == ($past(tlp_fmt[0]) ? 3'h4 : 3'h3) && dec_has_data == $past(tlp_fmt[1]))
      else $error("fmt decode wrong");
   a_strap_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      strap_valid && !qual_rise |=> $stable(st_if_reg) && $stable(st_dir_reg) && $stable(st_req_reg))
      else $error("straps changed while held");
   a_cpm_strap: assert property (@(posedge clk_sys) disable iff (!resetn)
      strap_valid && !st_hi_reg && st_req_reg == REQ_STRAP_CPM && !st_dir_reg ##1 strap_valid |=> cpm_enable)
      else $error("clock power management not enabled");
   a_smbus_pins: assert property (@(posedge clk_sys) disable iff (!resetn)
      smbus_mode |=> !scl_oe && (!sda_oe || !sda_o)) else $error("smbus pins driven wrongly");
   // live pin decode, one edge behind the synchronised pins
   a_fwd_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
      !tm_dir |=> !reverse_mode && internal_arbiter)
      else $error("forward bridge mode not taken");
   a_rev_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
      tm_dir |=> reverse_mode)
      else $error("reverse bridge mode not taken");
   a_smbus_select: assert property (@(posedge clk_sys) disable iff (!resetn)
      !tm_hi && tm_if |=> smbus_mode)
      else $error("smbus interface not selected");
   a_eeprom_select: assert property (@(posedge clk_sys) disable iff (!resetn)
      !tm_hi && !tm_if ##1 !tm_hi && !tm_if |=> !smbus_mode && scl_oe)
      else $error("eeprom interface not selected");
   // strap capture and the functions it picks
   a_strap_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
      qual_rise |=> strap_valid && st_dir_reg == $past(tm_dir) && st_req_reg == $past(req_s))
      else $error("straps not captured at reset release");
   // a reverse test strap must ignore perst and wait for the pci reset
   a_pcirst_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
      use_pcirst && !pcirst_s && !strap_valid |=> !strap_valid)
      else $error("straps taken before pci reset release");
   a_test_short: assert property (@(posedge clk_sys) disable iff (!resetn)
      strap_valid && st_hi_reg && st_if_reg |=> test_func == BMP_TF_SHORT_INIT)
      else $error("short initialization not selected");
   a_test_loop: assert property (@(posedge clk_sys) disable iff (!resetn)
      strap_valid && st_hi_reg && !st_if_reg && st_dir_reg |=> test_func == BMP_TF_LOOPBACK)
      else $error("loopback test not selected");
   a_test_bridge: assert property (@(posedge clk_sys) disable iff (!resetn)
      strap_valid && st_hi_reg && !st_if_reg && !st_dir_reg |=> test_func == BMP_TF_BRIDGE_TEST)
      else $error("bridge test not selected");
   a_cpm_clock_pins: assert property (@(posedge clk_sys) disable iff (!resetn)
      cpm_enable |-> pci_clock_out_2_is_clkreq && pci_clock_out_3_is_clkrun)
      else $error("clock outputs not repurposed");
   // tlp classes and the isochronous gate
   a_route_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && (is_mem || is_io) |=> dec_route == BMP_RT_ADDR)
      else $error("memory or io not address routed");
   a_route_id: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && is_cfg |=> dec_route == BMP_RT_ID)
      else $error("configuration not id routed");
   a_as_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && is_as |=> dec_unsupported && dec_route == BMP_RT_NONE)
      else $error("advanced switching message accepted");
   a_msg_tc: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_valid && is_msg && tlp_tc != 3'h0 |=> dec_malformed)
      else $error("message with nonzero tc not malformed");
   a_vi_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
      !vi_en |=> !dec_vi_tc_hit)
      else $error("isochronous hit while disabled");
   a_vi_upstream: assert property (@(posedge clk_sys) disable iff (!resetn)
      tlp_downstream |=> !dec_vi_tc_hit)
      else $error("isochronous hit on downstream traffic");
endmodule

// >>> bench/bmp_far_model.sv
// far-side serial bus: scl driven by the device when enabled, else by the host, and pulled-up sda shared by device and host
`timescale 1ns/1ns
module bmp_far_model (
   // device pin drive
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_o,
   input wire logic sda_oe,
   // host side
   input wire logic host_scl,
   input wire logic host_sda_low,
   // resolved wires
   output logic scl_wire,
   output logic sda_wire
);
   // ----------------------------------------
   // wire resolution
   // ----------------------------------------
   // host clocks scl only once the device lets go; a released sda floats up, never holds its last value
   assign scl_wire = scl_oe ? scl_o : host_scl;
   assign sda_wire = !((sda_oe && !sda_o) || host_sda_low);
endmodule

// >>> bench/tb_bmp_top.sv
// self-checking bench for the mode, strap and tlp policy block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; \
$display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module tb_bmp_top import bmp_pkg::*; ();
   typedef struct packed {logic dn; logic [1:0] f; logic [4:0] t; logic [2:0] c; logic [9:0] l;
      bmp_route_t r; logic mal; logic uns;} bmp_row_t;
   logic clk_sys, resetn, mode_select_hi, iface_select, direction_select, perst_n, pci_reset_n;
   logic ser_scl, ser_sda, ser_sda_en, tlp_valid, tlp_downstream, reg_wr, reg_rd, host_scl;
   logic scl_o, scl_oe, sda_o, sda_oe, smbus_mode, reverse_mode, internal_arbiter, strap_valid, cpm_enable;
   logic pci_clock_out_2_is_clkreq, pci_clock_out_3_is_clkrun, dec_valid, dec_has_data, dec_malformed;
   logic dec_unsupported, dec_to_pci, dec_vi_tc_hit, scl_w, sda_w;
   logic [1:0] pci_req_n, tlp_fmt;
   logic [4:0] tlp_type;
   logic [2:0] tlp_tc, dec_hdr_dw, dec_msg_dest;
   logic [9:0] tlp_length, reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   bmp_test_t test_func;
   bmp_route_t dec_route;
   bmp_row_t r;
   int err_count, checks, cyc;
   // fmt/type/tc/length rows; header size and data bit are worked out from fmt
   bmp_row_t rows [13] = '{
      '{1'b1, 2'h2, 5'h00, 3'h5, 10'h001, BMP_RT_ADDR, 1'b0, 1'b0},
      '{1'b1, 2'h3, 5'h00, 3'h0, 10'h040, BMP_RT_ADDR, 1'b0, 1'b0},
      '{1'b1, 2'h2, 5'h00, 3'h0, 10'h041, BMP_RT_ADDR, 1'b1, 1'b0},
      '{1'b1, 2'h2, 5'h00, 3'h0, 10'h000, BMP_RT_ADDR, 1'b1, 1'b0},
      '{1'b1, 2'h0, 5'h02, 3'h0, 10'h001, BMP_RT_ADDR, 1'b0, 1'b0},
      '{1'b1, 2'h0, 5'h02, 3'h1, 10'h001, BMP_RT_ADDR, 1'b1, 1'b0},
      '{1'b1, 2'h0, 5'h04, 3'h0, 10'h001, BMP_RT_ID, 1'b0, 1'b0},
      '{1'b1, 2'h2, 5'h05, 3'h7, 10'h001, BMP_RT_ID, 1'b1, 1'b0},
      '{1'b0, 2'h0, 5'h04, 3'h2, 10'h001, BMP_RT_ID, 1'b0, 1'b0},
      '{1'b1, 2'h1, 5'h13, 3'h0, 10'h001, BMP_RT_IMPL, 1'b0, 1'b0},
      '{1'b0, 2'h1, 5'h14, 3'h1, 10'h001, BMP_RT_IMPL, 1'b1, 1'b0},
      '{1'b1, 2'h1, 5'h18, 3'h0, 10'h001, BMP_RT_NONE, 1'b0, 1'b1},
      '{1'b1, 2'h0, 5'h00, 3'h0, 10'h000, BMP_RT_ADDR, 1'b0, 1'b0}};

   bmp_top DUT (.clk_sys, .resetn, .mode_select_hi, .iface_select, .direction_select, .pci_req_n, .perst_n,
      .pci_reset_n, .ser_scl, .ser_sda, .ser_sda_en, .scl_o, .scl_oe, .sda_o, .sda_oe, .smbus_mode,
      .reverse_mode, .internal_arbiter, .strap_valid, .cpm_enable, .pci_clock_out_2_is_clkreq,
      .pci_clock_out_3_is_clkrun, .test_func, .tlp_valid, .tlp_downstream, .tlp_fmt, .tlp_type, .tlp_tc,
      .tlp_length, .dec_valid, .dec_hdr_dw, .dec_has_data, .dec_route, .dec_msg_dest, .dec_malformed,
      .dec_unsupported, .dec_to_pci, .dec_vi_tc_hit, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   bmp_far_model far (.scl_o, .scl_oe, .sda_o, .sda_oe, .host_scl, .host_sda_low(1'b0),
      .scl_wire(scl_w), .sda_wire(sda_w));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic close_out();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // timeout
   // ----------------------------------------
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         close_out();
      end
   end

   task automatic rdr(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wrr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // pins change only while everything is in reset, then stay put
   task automatic strap(input logic [3:0] i);
      logic h, s, d, q;
      {h, s, d, q} = i;
      @(posedge clk_sys);
      {mode_select_hi, iface_select, direction_select} <= {h, s, d};
      pci_req_n <= q ? 2'h1 : 2'h0;
      perst_n <= 1'b0;
      pci_reset_n <= 1'b0;
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      perst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 `CHK("strap_valid", !(h && d), strap_valid)
      @(posedge clk_sys);
      pci_reset_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 `CHK("strap_valid", 1'b1, strap_valid)
      `CHK("cpm_enable", !h && !q && !d, cpm_enable)
      `CHK("clkreq", !h && !q && !d, pci_clock_out_2_is_clkreq)
      `CHK("clkrun", !h && !q && !d, pci_clock_out_3_is_clkrun)
      `CHK("test_func", !h ? BMP_TF_NONE : s ? BMP_TF_SHORT_INIT : d ? BMP_TF_LOOPBACK : BMP_TF_BRIDGE_TEST,
         test_func)
      `CHK("reverse_mode", d, reverse_mode)
      if (!h)
         `CHK("smbus_mode", s, smbus_mode)
      if (i == 4'h0)
         `CHK("internal_arbiter", 1'b1, internal_arbiter)
      rdr(10'h008, rd);
      `CHK("cap_info", {d ? PORT_REV : PORT_FWD, CAP_VERSION}, rd[7:0])
   endtask

   task automatic vi(input logic d, input logic [2:0] c, input logic ex);
      @(posedge clk_sys);
      tlp_valid <= 1'b1;
      {tlp_downstream, tlp_fmt, tlp_type, tlp_tc, tlp_length} <= {d, 2'h2, 5'h00, c, 10'h001};
      @(posedge clk_sys);
      tlp_valid <= 1'b0;
      #1 `CHK("vi_tc_hit", ex, dec_vi_tc_hit)
   endtask

   initial begin
      {resetn, mode_select_hi, iface_select, direction_select, perst_n, pci_reset_n} = 6'h00;
      {ser_scl, ser_sda, ser_sda_en, tlp_valid, tlp_downstream, reg_wr, reg_rd, host_scl} = 8'h00;
      {pci_req_n, tlp_fmt, tlp_type, tlp_tc, tlp_length, reg_addr, reg_wdata} = '0;
      err_count = 0;
      checks = 0;
      cyc = 0;
      @(posedge clk_sys);
      #1 `CHK("scl_o", 1'b1, scl_o)
      `CHK("hdr_dw", 3'h3, dec_hdr_dw)
      `CHK("route", BMP_RT_NONE, dec_route)
      for (int i = 0; i < 16; i++)
         strap(i[3:0]);
      // ----------------------------------------
      // tlp rows, one header per cycle
      // ----------------------------------------
      for (int i = 0; i <= 13; i++) begin
         @(posedge clk_sys);
         tlp_valid <= (i < 13);
         if (i < 13)
            {tlp_downstream, tlp_fmt, tlp_type, tlp_tc, tlp_length} <= rows[i][24:4];
         #1 if (i > 0) begin
            r = rows[i - 1];
            `CHK("dec_valid", 1'b1, dec_valid)
            `CHK("hdr_dw", r.f[0] ? 3'h4 : 3'h3, dec_hdr_dw)
            `CHK("has_data", r.f[1], dec_has_data)
            `CHK("route", r.r, dec_route)
            `CHK("malformed", r.mal, dec_malformed)
            `CHK("unsupported", r.uns, dec_unsupported)
            if (r.r == BMP_RT_IMPL)
               `CHK("msg_dest", r.t[2:0], dec_msg_dest)
            if (r.t == 5'h00 && r.dn && !r.mal)
               `CHK("to_pci", 1'b1, dec_to_pci)
         end
      end
      @(posedge clk_sys);
      #1 `CHK("dec_valid", 1'b0, dec_valid)
      // ----------------------------------------
      // virtual isochronous control and register refusals
      // ----------------------------------------
      rdr(10'h100, rd);
      `CHK("chip_ctrl", CHIP_CTRL_RST, rd)
      vi(1'b0, 3'h3, 1'b0);
      wrr(10'h008, 32'h0000_0000);
      rdr(10'h008, rd);
      `CHK("cap_info", {PORT_REV, CAP_VERSION}, rd[7:0])
      rdr(10'h004, rd);
      `CHK("unmapped", 32'h0000_0000, rd)
      wrr(10'h100, 32'h0408_0000);
      rdr(10'h100, rd);
      `CHK("chip_ctrl", 8'h81, {rd[26:24], rd[23:19]})
      vi(1'b0, 3'h3, 1'b1);
      vi(1'b0, 3'h2, 1'b0);
      vi(1'b1, 3'h3, 1'b0);
      // ----------------------------------------
      // strap hold and shared serial pins
      // ----------------------------------------
      strap(4'h0);
      ser_sda <= 1'b1;
      ser_sda_en <= 1'b1;
      pci_req_n <= 2'h3;
      repeat (8) @(posedge clk_sys);
      #1 `CHK("cpm_held", 1'b1, cpm_enable)
      `CHK("scl_wire", 1'b0, scl_w)
      `CHK("sda_wire", 1'b1, sda_w)
      rdr(10'h120, rd);
      `CHK("strap_stat", 9'h060, rd[8:0])
      perst_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      #1 `CHK("strap_valid", 1'b0, strap_valid)
      `CHK("cpm_enable", 1'b0, cpm_enable)
      strap(4'h4);
      ser_sda <= 1'b0;
      host_scl <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 `CHK("sda_oe", 1'b1, sda_oe)
      `CHK("sda_wire", 1'b0, sda_w)
      `CHK("scl_oe", 1'b0, scl_oe)
      ser_sda <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 `CHK("sda_oe", 1'b0, sda_oe)
      `CHK("sda_wire", 1'b1, sda_w)
      close_out();
   end
endmodule
